//--- rtl/disp_pkg.sv
// Shared constants, types and decode helpers for the display memory port.
`default_nettype none
package disp_pkg;
  localparam int CLK_PERIOD_NS = 5;
  localparam int CLK_HZ = 200_000_000;
  localparam int OSC_HZ = 57_000;
  localparam int OSC_HALF = CLK_HZ / (2 * OSC_HZ);
  localparam int SETTLE_TICKS = 3;
  localparam int FLASH_DIV = 28_672;
  localparam int GLYPH_ROWS = 7;
  localparam logic [7:0] SPACE_CODE = 8'h20;
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam logic [3:0] GLYPH_INDEX_RESET = 4'h0;
  localparam logic [2:0] BRIGHT_BLANK = 3'h7;
  localparam int CW_FLASH_BIT = 3;
  localparam int CW_BLINK_BIT = 4;
  localparam int CW_TEST_OK_BIT = 5;
  localparam int CW_CLEAR_BIT = 7;
  localparam int CHAR_TYPE_BIT = 7;
  localparam int T_ADDR_SETUP_NS = 10;
  localparam int T_STROBE_NS = 160;
  localparam int T_RECOVER_NS = 60;
  localparam int SETUP_CYC = (T_ADDR_SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int STROBE_CYC = (T_STROBE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int RECOVER_CYC = (T_RECOVER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [3:0] REG_ACCESS = 4'h0;
  localparam logic [3:0] REG_STATUS = 4'h4;
  localparam logic [3:0] REG_CONTROL = 4'h8;
  localparam int ACC_DATA_LSB = 0;
  localparam int ACC_ADDR_LSB = 8;
  localparam int ACC_BANK_BIT = 13;
  localparam int ACC_READ_BIT = 16;
  localparam int ST_BUSY_BIT = 8;
  localparam int ST_READY_BIT = 9;
  localparam int CT_CLS_BIT = 0;
  localparam int CT_INIT_BIT = 1;
  localparam logic [1:0] HOST_CTRL_RESET = 2'h1;

  typedef enum logic [2:0] {SEC_ATTR, SEC_GLYPH_INDEX, SEC_GLYPH_ROW, SEC_CONTROL, SEC_CHAR} section_t;

  function automatic section_t decode_section(input logic bank_n, input logic [1:0] upper);
    section_t s;
    s = SEC_CHAR;
    if (!bank_n) begin
      s = SEC_ATTR;
    end else if (upper == 2'h0) begin
      s = SEC_GLYPH_INDEX;
    end else if (upper == 2'h1) begin
      s = SEC_GLYPH_ROW;
    end else if (upper == 2'h2) begin
      s = SEC_CONTROL;
    end
    return s;
  endfunction : decode_section
endpackage : disp_pkg
`default_nettype wire

//--- rtl/disp_link_if.sv
// Parallel host port wires between the microprocessor end and the display end.
`default_nettype none
interface disp_link_if;
  logic init_pin_n;
  logic attribute_bank_select_n;
  logic [4:0] addr;
  logic chip_select_n;
  logic store_strobe_n;
  logic fetch_strobe_n;
  logic clock_source_select;
  logic [7:0] host_data_o;
  logic host_data_oe_n;
  logic [7:0] dev_data_o;
  logic dev_data_oe_n;
  logic dev_clk_o;
  logic dev_clk_oe_n;
  logic host_clk_o;
  logic host_clk_oe_n;
  logic [7:0] data;
  logic clk_pin;

  // An undriven bus floats high, as the pull-ups would leave it.
  assign data = !dev_data_oe_n ? dev_data_o : (!host_data_oe_n ? host_data_o : 8'hff);
  assign clk_pin = !dev_clk_oe_n ? dev_clk_o : (!host_clk_oe_n ? host_clk_o : 1'b0);

  modport dev (
    input init_pin_n, attribute_bank_select_n, addr, chip_select_n, store_strobe_n,
    input fetch_strobe_n, clock_source_select, data, clk_pin,
    output dev_data_o, dev_data_oe_n, dev_clk_o, dev_clk_oe_n
  );
  modport host (
    output init_pin_n, attribute_bank_select_n, addr, chip_select_n, store_strobe_n,
    output fetch_strobe_n, clock_source_select, host_data_o, host_data_oe_n, host_clk_o, host_clk_oe_n,
    input data, clk_pin
  );
endinterface : disp_link_if
`default_nettype wire

//--- rtl/ascii_glyph_rom.sv
// Row pattern source for the built-in character decoder.
`default_nettype none
module ascii_glyph_rom (
  input wire logic [6:0] code,
  input wire logic [2:0] row,
  output logic [4:0] row_bits
);
  import disp_pkg::*;
  // The real font is not held here; printable codes show a framed cell so that lit
  // positions stay visible, and codes up to and including the space stay dark.
  wire printable = code > SPACE_CODE[6:0];
  wire edge_row = (row == 3'h0) || (row == 3'(GLYPH_ROWS - 1));
  assign row_bits = !printable ? 5'h00 : (edge_row ? 5'h1f : 5'h11);
endmodule : ascii_glyph_rom
`default_nettype wire

//--- rtl/display_device.sv
// Eight-character dot-matrix display: memory port, storage and refresh.
// Notes on behaviour
// - Low bank select picks attribute RAM.
// - Upper address bits pick the other sections.
// - Low three address bits pick location.
// - Clock select chooses internal or external clock.
// - Clock pin drives out or takes in.
// - Write when store strobe and select low.
// - Read drives data while strobe, select low.
// - Host raises select between accesses.
// - Exactly one strobe low per access.
// - Host holds address while select low.
// - Bit 7 chooses decoder or custom glyph.
// - Code in bits 0-6, index 0-3.
// - Eight chars, 128-code decoder, 16 glyphs.
// - One attribute bit per position.
// - Glyph index register, low four bits used.
// - Host loads glyph index before rows.
// - One index write, seven row writes.
// - Row by address, pattern bits 0-4.
// - Bit 0 right column, bit 4 left.
// - Refresh continuously drives eight characters.
// - Reset pin blanks text, keeps glyphs.
// - Host waits three clocks after reset.
// - Attribute bit 0 sets or removes flash.
`default_nettype none
module display_device #(
  parameter int FLASH_TICKS = disp_pkg::FLASH_DIV
) (
  input wire logic clk,
  input wire logic rst_n,
  disp_link_if.dev link,
  output var logic [4:0] dot_columns,
  output var logic [2:0] digit_sel,
  output var logic [2:0] row_sel
);
  import disp_pkg::*;

  // Every pin passes two flip-flops before anything looks at it.
  localparam int SW = 20;
  logic [SW-1:0] meta_q;
  logic [SW-1:0] sync_q;
  wire [SW-1:0] raw = {link.init_pin_n, link.attribute_bank_select_n, link.chip_select_n,
                       link.store_strobe_n, link.fetch_strobe_n, link.clock_source_select,
                       link.clk_pin, link.addr, link.data};
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_q <= '0;
      sync_q <= '0;
    end else begin
      meta_q <= raw;
      sync_q <= meta_q;
    end
  end
  wire init_s = sync_q[19];
  wire bank_s = sync_q[18];
  wire cs_s = sync_q[17];
  wire wr_s = sync_q[16];
  wire rd_s = sync_q[15];
  wire cls_s = sync_q[14];
  wire ext_s = sync_q[13];
  wire [4:0] addr_s = sync_q[12:8];
  wire [7:0] data_s = sync_q[7:0];

  // Timing ticks come from the internal divider or from edges on the clock pin.
  logic [10:0] osc_cnt_q;
  logic osc_q;
  logic ext_prev_q;
  logic clk_oe_n_q;
  wire osc_wrap = osc_cnt_q == 11'(OSC_HALF - 1);
  wire int_tick = osc_wrap && !osc_q;
  wire ext_tick = ext_s && !ext_prev_q;
  wire tick = cls_s ? int_tick : ext_tick;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      osc_cnt_q <= '0;
      osc_q <= 1'b0;
      ext_prev_q <= 1'b0;
      clk_oe_n_q <= 1'b1;
    end else begin
      osc_cnt_q <= osc_wrap ? 11'h000 : osc_cnt_q + 11'h001;
      osc_q <= osc_wrap ? !osc_q : osc_q;
      ext_prev_q <= ext_s;
      clk_oe_n_q <= !cls_s;
    end
  end
  assign link.dev_clk_o = osc_q;
  assign link.dev_clk_oe_n = clk_oe_n_q;

  // Storage.
  logic [7:0] char_ram [8];
  logic [7:0] attr_q;
  logic [7:0] ctrl_q;
  logic [3:0] glyph_idx_q;
  logic [4:0] glyph_ram [16][GLYPH_ROWS];
  logic [1:0] settle_q;
  logic done_q;

  // Accesses are ignored while the reset or clear sequence settles.
  wire busy = settle_q != 2'h0;
  wire sel = init_s && !cs_s && !busy;
  wire wr_act = sel && !wr_s && rd_s;
  wire rd_act = sel && !rd_s && wr_s;
  // One write per select period, so a long strobe stores once.
  wire do_write = wr_act && !done_q;
  wire section_t sec = decode_section(bank_s, addr_s[4:3]);
  wire [2:0] loc = addr_s[2:0];
  wire row_ok = loc < 3'(GLYPH_ROWS);
  wire wr_char = do_write && sec == SEC_CHAR;
  wire wr_attr = do_write && sec == SEC_ATTR;
  wire wr_ctrl = do_write && sec == SEC_CONTROL;
  wire wr_index = do_write && sec == SEC_GLYPH_INDEX;
  wire wr_row = do_write && sec == SEC_GLYPH_ROW && row_ok;
  wire start_clear = wr_ctrl && data_s[CW_CLEAR_BIT];
  wire pin_reset = !init_s;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      done_q <= 1'b0;
      settle_q <= 2'(SETTLE_TICKS);
    end else begin
      done_q <= cs_s ? 1'b0 : (done_q || wr_act);
      if (pin_reset || start_clear) begin
        settle_q <= 2'(SETTLE_TICKS);
      end else if (tick && busy) begin
        settle_q <= settle_q - 2'h1;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < 8; i++) begin
        char_ram[i] <= SPACE_CODE;
      end
      attr_q <= '0;
      ctrl_q <= CTRL_RESET;
    end else if (pin_reset) begin
      for (int i = 0; i < 8; i++) begin
        char_ram[i] <= SPACE_CODE;
      end
      attr_q <= '0;
      ctrl_q <= CTRL_RESET;
    end else if (start_clear) begin
      for (int i = 0; i < 8; i++) begin
        char_ram[i] <= SPACE_CODE;
      end
      attr_q <= '0;
      ctrl_q <= {1'b1, data_s[6], 1'b0, data_s[4:0]};
    end else begin
      if (wr_char) begin
        char_ram[loc] <= data_s;
      end
      if (wr_attr) begin
        attr_q[loc] <= data_s[0];
      end
      if (wr_ctrl) begin
        // The self-test result bit is read-only and keeps its value.
        ctrl_q <= {data_s[7:6], ctrl_q[CW_TEST_OK_BIT], data_s[4:0]};
      end else if (ctrl_q[CW_CLEAR_BIT] && !busy) begin
        ctrl_q[CW_CLEAR_BIT] <= 1'b0;
      end
    end
  end

  // Glyph storage survives the reset pin on purpose: custom symbols are loaded once.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      glyph_idx_q <= GLYPH_INDEX_RESET;
    end else if (wr_index) begin
      glyph_idx_q <= data_s[3:0];
    end
  end
  always_ff @(posedge clk) begin
    if (wr_row) begin
      glyph_ram[glyph_idx_q][loc] <= data_s[4:0];
    end
  end

  // Read path.
  wire [4:0] row_rd = row_ok ? glyph_ram[glyph_idx_q][loc] : 5'h00;
  wire [7:0] rd_word = (sec == SEC_ATTR) ? {7'h00, attr_q[loc]} :
                       (sec == SEC_GLYPH_INDEX) ? {4'h0, glyph_idx_q} :
                       (sec == SEC_GLYPH_ROW) ? {3'h0, row_rd} :
                       (sec == SEC_CONTROL) ? ctrl_q : char_ram[loc];
  logic [7:0] dout_q;
  logic doe_n_q;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      dout_q <= '0;
      doe_n_q <= 1'b1;
    end else begin
      dout_q <= rd_word;
      doe_n_q <= !rd_act;
    end
  end
  assign link.dev_data_o = dout_q;
  assign link.dev_data_oe_n = doe_n_q;

  // Refresh scan, one row step per tick.
  logic [2:0] scan_digit_q;
  logic [2:0] scan_row_q;
  logic [14:0] flash_cnt_q;
  logic flash_phase_q;
  logic [2:0] dim_q;
  wire row_wrap = scan_row_q == 3'(GLYPH_ROWS - 1);
  wire flash_wrap = flash_cnt_q == 15'(FLASH_TICKS / 2 - 1);
  wire [7:0] code = char_ram[scan_digit_q];
  wire [4:0] ascii_row;
  ascii_glyph_rom rom (
    .code(code[6:0]),
    .row(scan_row_q),
    .row_bits(ascii_row)
  );
  wire [4:0] custom_row = glyph_ram[code[3:0]][scan_row_q];
  wire [4:0] pattern = code[CHAR_TYPE_BIT] ? custom_row : ascii_row;
  wire [2:0] bright = ctrl_q[2:0];
  wire flash_off = ctrl_q[CW_FLASH_BIT] && attr_q[scan_digit_q] && flash_phase_q;
  wire blink_off = ctrl_q[CW_BLINK_BIT] && flash_phase_q;
  // Dimming is a coarse duty cycle on the clock, traded for a tiny counter.
  wire dark = bright == BRIGHT_BLANK || dim_q < bright || flash_off || blink_off;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      scan_digit_q <= '0;
      scan_row_q <= '0;
      flash_cnt_q <= '0;
      flash_phase_q <= 1'b0;
      dim_q <= '0;
      dot_columns <= '0;
      digit_sel <= '0;
      row_sel <= '0;
    end else begin
      dim_q <= dim_q + 3'h1;
      if (pin_reset) begin
        flash_cnt_q <= '0;
        flash_phase_q <= 1'b0;
      end else if (tick) begin
        flash_cnt_q <= flash_wrap ? 15'h0000 : flash_cnt_q + 15'h0001;
        flash_phase_q <= flash_wrap ? !flash_phase_q : flash_phase_q;
        scan_row_q <= row_wrap ? 3'h0 : scan_row_q + 3'h1;
        scan_digit_q <= row_wrap ? scan_digit_q + 3'h1 : scan_digit_q;
      end
      dot_columns <= dark ? 5'h00 : pattern;
      digit_sel <= scan_digit_q;
      row_sel <= scan_row_q;
    end
  end
endmodule : display_device
`default_nettype wire

//--- rtl/display_host.sv
// Microprocessor end: runs pin cycles on the display port from Avalon-MM orders.
`default_nettype none
module display_host (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [3:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output var logic [31:0] avs_readdata,
  output var logic avs_waitrequest,
  disp_link_if.host link
);
  import disp_pkg::*;

  typedef enum {ST_IDLE, ST_SETUP, ST_STROBE, ST_RECOVER} state_t;

  logic [8:0] meta_q;
  logic [8:0] sync_q;
  logic clk_prev_q;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_q <= '0;
      sync_q <= '0;
      clk_prev_q <= 1'b0;
    end else begin
      meta_q <= {link.clk_pin, link.data};
      sync_q <= meta_q;
      clk_prev_q <= sync_q[8];
    end
  end
  wire [7:0] data_s = sync_q[7:0];
  wire clk_rise = sync_q[8] && !clk_prev_q;

  logic [1:0] ctrl_q;
  logic [1:0] settle_q;
  logic [10:0] div_q;
  logic xclk_q;
  logic [4:0] init_age_q;
  logic [3:0] ext_age_q;
  logic xclk_oe_n_q;
  wire div_wrap = div_q == 11'(OSC_HALF - 1);
  wire ready = settle_q == 2'(SETTLE_TICKS);
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      settle_q <= '0;
      div_q <= '0;
      xclk_q <= 1'b0;
      init_age_q <= '0;
      ext_age_q <= '0;
      xclk_oe_n_q <= 1'b1;
    end else begin
      div_q <= div_wrap ? 11'h000 : div_q + 11'h001;
      xclk_q <= div_wrap ? !xclk_q : xclk_q;
      // Edges the display sees before it has synchronised the released pin are not counted.
      init_age_q <= ctrl_q[CT_INIT_BIT] ? 5'h00 : {init_age_q[3:0], 1'b1};
      // The display needs a few cycles to let go of the clock pin, so our drive waits.
      ext_age_q <= ctrl_q[CT_CLS_BIT] ? 4'h0 : {ext_age_q[2:0], 1'b1};
      xclk_oe_n_q <= ctrl_q[CT_CLS_BIT] || !ext_age_q[3];
      // Count clock edges after the reset pin rises before any access.
      if (ctrl_q[CT_INIT_BIT]) begin
        settle_q <= '0;
      end else if (clk_rise && init_age_q[4] && !ready) begin
        settle_q <= settle_q + 2'h1;
      end
    end
  end
  assign link.clock_source_select = ctrl_q[CT_CLS_BIT];
  assign link.init_pin_n = !ctrl_q[CT_INIT_BIT];
  assign link.host_clk_o = xclk_q;
  assign link.host_clk_oe_n = xclk_oe_n_q;

  state_t state_q;
  logic [5:0] timer_q;
  logic is_read_q;
  logic cs_n_q;
  logic wr_n_q;
  logic rd_n_q;
  logic bank_n_q;
  logic [4:0] addr_q;
  logic [7:0] dout_q;
  logic doe_n_q;
  logic [7:0] rdata_q;

  wire idle = state_q == ST_IDLE;
  wire is_access = avs_address == REG_ACCESS;
  wire accept_ok = !(avs_write && is_access) || (idle && ready);
  wire go = (avs_read || avs_write) && avs_waitrequest && accept_ok;
  wire commit = avs_write && !avs_waitrequest;
  wire start = commit && is_access;
  wire [31:0] status = {22'h00_0000, ready, !idle, rdata_q};
  wire [31:0] rd_mux = (avs_address == REG_STATUS) ? status :
                       (avs_address == REG_CONTROL) ? {30'h0000_0000, ctrl_q} : 32'h0000_0000;
  wire timer_done = timer_q == 6'h00;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      avs_waitrequest <= 1'b1;
      avs_readdata <= '0;
      ctrl_q <= HOST_CTRL_RESET;
    end else begin
      avs_waitrequest <= !go;
      if (go) begin
        avs_readdata <= rd_mux;
      end
      if (commit && avs_address == REG_CONTROL) begin
        ctrl_q <= avs_writedata[1:0];
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= ST_IDLE;
      timer_q <= '0;
      is_read_q <= 1'b0;
      cs_n_q <= 1'b1;
      wr_n_q <= 1'b1;
      rd_n_q <= 1'b1;
      bank_n_q <= 1'b1;
      addr_q <= '0;
      dout_q <= '0;
      doe_n_q <= 1'b1;
      rdata_q <= '0;
    end else begin
      if (!timer_done) begin
        timer_q <= timer_q - 6'h01;
      end
      case (state_q)
        ST_IDLE: begin
          if (start) begin
            // Address is set here and held until select rises again.
            addr_q <= avs_writedata[ACC_ADDR_LSB +: 5];
            bank_n_q <= !avs_writedata[ACC_BANK_BIT];
            is_read_q <= avs_writedata[ACC_READ_BIT];
            dout_q <= avs_writedata[ACC_DATA_LSB +: 8];
            doe_n_q <= avs_writedata[ACC_READ_BIT];
            cs_n_q <= 1'b0;
            timer_q <= 6'(SETUP_CYC - 1);
            state_q <= ST_SETUP;
          end
        end
        ST_SETUP: begin
          if (timer_done) begin
            wr_n_q <= is_read_q;
            rd_n_q <= !is_read_q;
            timer_q <= 6'(STROBE_CYC - 1);
            state_q <= ST_STROBE;
          end
        end
        ST_STROBE: begin
          if (timer_done) begin
            if (is_read_q) begin
              rdata_q <= data_s;
            end
            wr_n_q <= 1'b1;
            rd_n_q <= 1'b1;
            cs_n_q <= 1'b1;
            doe_n_q <= 1'b1;
            timer_q <= 6'(RECOVER_CYC - 1);
            state_q <= ST_RECOVER;
          end
        end
        ST_RECOVER: begin
          if (timer_done) begin
            state_q <= ST_IDLE;
          end
        end
        default: begin
          state_q <= ST_IDLE;
        end
      endcase
    end
  end
  assign link.chip_select_n = cs_n_q;
  assign link.store_strobe_n = wr_n_q;
  assign link.fetch_strobe_n = rd_n_q;
  assign link.attribute_bank_select_n = bank_n_q;
  assign link.addr = addr_q;
  assign link.host_data_o = dout_q;
  assign link.host_data_oe_n = doe_n_q;
endmodule : display_host
`default_nettype wire

//--- verif/disp_link_sva.sv
// Concurrent checks on the port wires that join the host end and the display end.
`default_nettype none
module disp_link_sva (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic init_pin_n,
  input wire logic attribute_bank_select_n,
  input wire logic [4:0] addr,
  input wire logic chip_select_n,
  input wire logic store_strobe_n,
  input wire logic fetch_strobe_n,
  input wire logic clock_source_select,
  input wire logic host_data_oe_n,
  input wire logic dev_data_oe_n,
  input wire logic dev_clk_oe_n,
  input wire logic host_clk_oe_n
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0] up_q;
  logic [3:0] idle_q;
  logic [13:0] since_q;
  wire reading = !fetch_strobe_n && !chip_select_n;

  // Cycles since the reset pin was last released; three slow clocks are well above the bound.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      since_q <= 14'h0000;
    end else if (!init_pin_n) begin
      since_q <= 14'h0000;
    end else if (since_q != 14'h3fff) begin
      since_q <= since_q + 14'h0001;
    end
  end

  // The internal-source clock pin check waits for the synchronisers to fill after reset.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      up_q <= 4'h0;
    end else if (up_q != 4'hf) begin
      up_q <= up_q + 4'h1;
    end
  end
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      idle_q <= 4'h0;
    end else if (reading) begin
      idle_q <= 4'h0;
    end else if (idle_q != 4'hf) begin
      idle_q <= idle_q + 4'h1;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  a_bus_released: assert property (idle_q > 4'h5 |-> dev_data_oe_n)
    else $error("display drives the data bus outside a read");
  a_read_cause: assert property ($fell(dev_data_oe_n) |-> !$past(fetch_strobe_n, 2) && !$past(chip_select_n, 2))
    else $error("read drive started without read strobe and select");
  a_write_drive: assert property (!store_strobe_n |-> !host_data_oe_n && dev_data_oe_n)
    else $error("write strobe without host data drive");
  a_write_width: assert property ($fell(store_strobe_n) |-> !store_strobe_n [*8])
    else $error("write strobe too short");
  a_one_strobe: assert property (store_strobe_n || fetch_strobe_n)
    else $error("both strobes low");
  a_strobe_in_cs: assert property (!(store_strobe_n && fetch_strobe_n) |-> !chip_select_n)
    else $error("strobe low without chip select");
  a_cs_gap: assert property ($rose(chip_select_n) |-> chip_select_n [*8])
    else $error("chip select not held high between accesses");
  a_addr_hold: assert property (!chip_select_n && !$past(chip_select_n)
    |-> $stable(addr) && $stable(attribute_bank_select_n))
    else $error("address moved while selected");
  a_clk_internal: assert property (up_q > 4'h8 && clock_source_select && $past(clock_source_select, 4)
    |-> !dev_clk_oe_n)
    else $error("display not driving clock pin with internal source");
  a_clk_external: assert property (!clock_source_select && !$past(clock_source_select, 4) |-> dev_clk_oe_n)
    else $error("display drives clock pin with external source");
  a_host_clk: assert property (!host_clk_oe_n |-> dev_clk_oe_n)
    else $error("both ends drive the clock pin");
  a_settle_wait: assert property (since_q < 14'h1b00 |-> chip_select_n)
    else $error("access too soon after reset pin release");
endmodule : disp_link_sva
`default_nettype wire

//--- verif/test_smart_display_memory_port.sv
// Self-checking bench: Avalon orders into the host end, both ends joined by the port interface.
`default_nettype none
module test_smart_display_memory_port;
  timeunit 1ns;
  timeprecision 1ps;
  import disp_pkg::*;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [3:0] avs_address = 4'h0;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0000_0000;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic [4:0] dot_columns;
  logic [2:0] digit_sel;
  logic [2:0] row_sel;
  int mismatches = 0;
  int checked = 0;
  int seed = 90;
  logic [31:0] rd;
  logic [7:0] q;
  logic [7:0] d;
  logic [7:0] row0;
  logic [5:0] scan;

  disp_link_if link ();
  display_host i_display_host (.clk(clk), .rst_n(rst_n), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .link(link.host));
  display_device #(.FLASH_TICKS(8)) i_display_device (.clk(clk), .rst_n(rst_n), .link(link.dev),
    .dot_columns(dot_columns), .digit_sel(digit_sel), .row_sel(row_sel));
  disp_link_sva i_disp_link_sva (.clk(clk), .rst_n(rst_n), .init_pin_n(link.init_pin_n), .addr(link.addr),
    .attribute_bank_select_n(link.attribute_bank_select_n), .chip_select_n(link.chip_select_n),
    .store_strobe_n(link.store_strobe_n), .fetch_strobe_n(link.fetch_strobe_n),
    .clock_source_select(link.clock_source_select), .host_data_oe_n(link.host_data_oe_n),
    .dev_data_oe_n(link.dev_data_oe_n), .dev_clk_oe_n(link.dev_clk_oe_n), .host_clk_oe_n(link.host_clk_oe_n));

  always #2.5 clk = ~clk;

  function automatic logic [7:0] f_index(input logic [7:0] v);
    return {4'h0, v[3:0]};
  endfunction : f_index
  function automatic logic [7:0] f_row(input logic [7:0] v);
    return {3'h0, v[4:0]};
  endfunction : f_row
  function automatic logic [5:0] f_scan(input logic [5:0] s);
    return (s[2:0] == 3'(GLYPH_ROWS - 1)) ? {s[5:3] + 3'h1, 3'h0} : {s[5:3], s[2:0] + 3'h1};
  endfunction : f_scan

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      mismatches++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic close_out();
    if (mismatches == 0 && checked > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : close_out
  // One Avalon transfer; the request holds until waitrequest is sampled low.
  task automatic av(input logic [3:0] a, input logic wr, input logic [31:0] wd);
    int n;
    n = 0;
    @(posedge clk);
    avs_address <= a;
    avs_write <= wr;
    avs_read <= !wr;
    avs_writedata <= wd;
    @(posedge clk);
    while (avs_waitrequest !== 1'b0 && n < 40000) begin
      @(posedge clk);
      n++;
    end
    if (n >= 40000) begin
      mismatches++;
    end
    rd = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
  endtask : av
  // One pin cycle on the display port, then wait until the host end is idle again.
  task automatic acc(input logic bank, input logic [4:0] a, input logic rdn, input logic [7:0] wd);
    int n;
    n = 0;
    av(REG_ACCESS, 1'b1, {15'h0, rdn, 2'h0, bank, a, wd});
    rd = 32'h0000_0100;
    while (rd[ST_BUSY_BIT] !== 1'b0 && n < 2000) begin
      av(REG_STATUS, 1'b0, 32'h0000_0000);
      n++;
    end
    if (n >= 2000) begin
      mismatches++;
    end
    q = rd[7:0];
  endtask : acc
  task automatic check_blank();
    for (int i = 0; i < 8; i++) begin
      acc(1'b0, {2'h3, i[2:0]}, 1'b1, 8'h00);
      check({24'h0, q}, {24'h0, SPACE_CODE});
      acc(1'b1, {2'($random(seed)), i[2:0]}, 1'b1, 8'h00);
      check({31'h0, q[0]}, 32'h0000_0000);
    end
    acc(1'b0, 5'h10, 1'b1, 8'h00);
    check({24'h0, q}, {24'h0, CTRL_RESET});
  endtask : check_blank

  initial begin
    repeat (95000) @(posedge clk);
    mismatches++;
    close_out();
  end

  initial begin
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    check_blank();
    acc(1'b0, 5'h00, 1'b0, 8'ha5);
    acc(1'b0, 5'h06, 1'b1, 8'h00);
    check({24'h0, q}, {24'h0, f_index(8'ha5)});
    for (int r = 0; r < GLYPH_ROWS; r++) begin
      d = 8'($random(seed));
      if (r == 0) begin
        row0 = f_row(d);
      end
      acc(1'b0, {2'h1, r[2:0]}, 1'b0, d);
      acc(1'b0, {2'h1, r[2:0]}, 1'b1, 8'h00);
      check({24'h0, q}, {24'h0, f_row(d)});
    end
    // Custom flag and the top ASCII code sit at the two ends of the row.
    for (int i = 0; i < 8; i++) begin
      d = (i == 0) ? 8'h80 : ((i == 7) ? 8'h7f : 8'($random(seed)));
      acc(1'b0, {2'h3, i[2:0]}, 1'b0, d);
      acc(1'b1, {2'($random(seed)), i[2:0]}, 1'b0, {7'h0, d[0]});
      acc(1'b0, {2'h3, i[2:0]}, 1'b1, 8'h00);
      check({24'h0, q}, {24'h0, d});
      acc(1'b1, {2'($random(seed)), i[2:0]}, 1'b1, 8'h00);
      check({31'h0, q[0]}, {31'h0, d[0]});
    end
    acc(1'b0, 5'h12, 1'b0, 8'h3b);
    acc(1'b0, 5'h15, 1'b1, 8'h00);
    check({24'h0, q}, 32'h0000_001b);
    av(4'hc, 1'b0, 32'h0000_0000);
    check(rd, 32'h0000_0000);
    // Pulse the reset pin: text and flags clear, glyph store and index survive.
    av(REG_CONTROL, 1'b1, 32'h0000_0003);
    repeat (8) @(posedge clk);
    av(REG_CONTROL, 1'b1, 32'h0000_0001);
    check_blank();
    acc(1'b0, 5'h01, 1'b1, 8'h00);
    check({24'h0, q}, {24'h0, f_index(8'ha5)});
    acc(1'b0, 5'h08, 1'b1, 8'h00);
    check({24'h0, q}, {24'h0, row0});
    av(REG_CONTROL, 1'b1, 32'h0000_0000);
    repeat (20) @(posedge clk);
    acc(1'b0, 5'h1a, 1'b0, 8'h41);
    acc(1'b0, 5'h1a, 1'b1, 8'h00);
    check({24'h0, q}, 32'h0000_0041);
    // The scan takes one row step on the external clock; the expected position wraps after the last glyph row.
    scan = {digit_sel, row_sel};
    for (int k = 0; k < 4000 && {digit_sel, row_sel} == scan; k++) begin
      @(posedge clk);
    end
    check({26'h0, digit_sel, row_sel}, {26'h0, f_scan(scan)});
    acc(1'b0, 5'h10, 1'b0, 8'h07);
    repeat (4) @(posedge clk);
    check({27'h0, dot_columns}, 32'h0000_0000);
    close_out();
  end
endmodule : test_smart_display_memory_port
`default_nettype wire
